// File: src/ssra_core.sv
// Two-wire slave and pointer register file of the temperature monitor
//
// Contract
// - Thirteen data registers, chosen by the 8-bit pointer.
// - Pointer clears to zero at power-up, selecting local temperature.
// - Pointer keeps its value until a new command byte.
// - Reading flags clears them unless the comparison still shows a fault.
// - Other registers are read-only or write-only by address.
// - Write-only address value reads back at the paired read address; config keeps only its used bits.
// - Writes carry address, command, then exactly one data byte.
// - Read with address only when the pointer already fits.
// - Read elsewhere: address, command, repeated start, address, data.
// - Data bytes leave most significant bit first.
// - Master ack after read data loads the next byte; master nack ends the read cleanly.
// - A line low 40 ms or more returns the slave to idle.
// - Between 25 and 40 ms low, resetting is optional.
// - Any start condition restarts and expects an address byte.
// - Command byte of a write loads the pointer.
// - Locations 00h, 01h, 02h give temperatures and flags, zero at reset.
// - Locations 05h, 07h, 42h read the limits, reset to 127.
// - Locations 0Bh, 0Dh, 5Ah write the limits.
// - Locations FEh, FFh give maker and revision codes.
// - Flag bits 0,1,2,4,6 as listed; others read zero.
// - Slave address bit 3 is one; rest from select pins.
`timescale 1ns/10ps
module ssra_core
   import ssra_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter logic [7:0] MAKER_CODE = 8'hA5,  // arbitrary value
   parameter logic [7:0] DIE_REVISION = 8'h5C  // arbitrary value
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Two-wire bus pins (data is open drain)
   input wire logic serial_clock_line,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe,
   // Address select pins: 0 low, 1 high, 2 floating
   input wire logic [1:0] addr_select_0,
   input wire logic [1:0] addr_select_1,
   // Conversion results from the same clock domain
   input wire logic conv_done,
   input wire logic [7:0] local_temp_in,
   input wire logic [7:0] remote_temp_in,
   input wire logic [7:0] fault_cond,
   // Setpoints for the comparison logic
   output logic [7:0] config_value,
   output logic [7:0] local_high_limit,
   output logic [7:0] remote_high_limit,
   output logic [7:0] critical_limit,
   // Alarm levels from the sticky flags
   output logic high_alarm_out,
   output logic critical_alarm_out
);

   logic [5:0] sync_q;
   logic scl_s;
   logic sda_s;
   logic [1:0] sel0_s;
   logic [1:0] sel1_s;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic to_expired;
   logic addr_valid;
   logic [6:0] slave_addr;
   logic [6:0] pin_addr;
   ssra_state_t st;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic rd_dir;
   logic master_nack;
   logic sda_oe;
   logic rx_state;
   logic byte_in_done;
   logic cmd_done;
   logic wr_strobe;
   logic load_tx;
   logic status_rd;
   logic [7:0] rd_data;
   logic [7:0] register_pointer;
   logic [7:0] local_temp_value;
   logic [7:0] remote_temp_value;
   logic [7:0] alarm_flags;
   logic [7:0] next_flags;

   // ==========================================================
   // Pin synchronisation and line events
   ssra_sync #(
      .W(6)
   ) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .d({serial_clock_line, serial_data_line_in, addr_select_0, addr_select_1}),
      .q(sync_q)
   );

   assign scl_s = sync_q[5];
   assign sda_s = sync_q[4];
   assign sel0_s = sync_q[3:2];
   assign sel1_s = sync_q[1:0];

   // Previous line levels, idle high
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (clk_en) begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Data changes while the clock is high mark start and stop
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_det = scl_s && scl_d && sda_d && !sda_s;
   assign stop_det = scl_s && scl_d && !sda_d && sda_s;

   // ==========================================================
   // Stuck-line watchdog, fires between the 25 and 40 ms marks
   ssra_timeout #(
      .CYC(TIMEOUT_CYCLES)
   ) u_timeout (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .scl(scl_s),
      .sda(sda_s),
      .expired(to_expired)
   );

   // ==========================================================
   // Slave address from the select pins
   always_comb begin
      logic [2:0] hi;
      logic [2:0] base;
      logic [2:0] step;
      hi = HI_LOW;
      base = LO_BASE_LOW;
      step = LO_STEP_LOW;
      case (sel0_s)
         PIN_HIGH: begin
            hi = HI_HIGH;
            base = LO_BASE_HIGH;
         end
         PIN_FLOAT: begin
            hi = HI_FLOAT;
            base = LO_BASE_FLOAT;
         end
         default: ;
      endcase
      case (sel1_s)
         PIN_HIGH: step = LO_STEP_HIGH;
         PIN_FLOAT: step = LO_STEP_FLOAT;
         default: step = LO_STEP_LOW;
      endcase
      pin_addr = {hi, ADDR_FIXED_ONE, 3'(base + step)};
   end

   // Pins are caught at the first bus start and then ignored
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         addr_valid <= 1'b0;
         slave_addr <= 7'h00;
      end else if (clk_en && start_det && !addr_valid) begin
         addr_valid <= 1'b1;
         slave_addr <= pin_addr;
      end
   end

   // ==========================================================
   // Byte framing
   assign rx_state = (st == S_ADDR) || (st == S_CMD) || (st == S_WDATA);
   assign byte_in_done = rx_state && scl_fall && (bitcnt == BYTE_BITS);
   assign cmd_done = byte_in_done && (st == S_CMD);
   assign wr_strobe = byte_in_done && (st == S_WDATA);
   // Address-only read reuses the stored pointer; ack reloads it
   assign load_tx = scl_fall && (((st == S_AACK) && rd_dir) ||
                                 ((st == S_RACK) && !master_nack));
   assign status_rd = load_tx && (register_pointer == LOC_FLAGS);

   // ==========================================================
   // Serial state machine
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st <= S_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         rd_dir <= 1'b0;
         master_nack <= 1'b0;
         sda_oe <= 1'b0;
      end else if (clk_en) begin
         if (start_det) begin
            st <= S_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (to_expired || stop_det) begin
            st <= S_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (st)
               S_ADDR, S_CMD, S_WDATA: begin
                  if (scl_rise && bitcnt != BYTE_BITS) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (byte_in_done) begin
                     if (st != S_ADDR) begin
                        // Command and first data byte always acked, even if ignored
                        st <= (st == S_CMD) ? S_CACK : S_WACK;
                        sda_oe <= 1'b1;
                     end else if (addr_valid && shreg[7:1] == slave_addr) begin
                        st <= S_AACK;
                        rd_dir <= shreg[0];
                        sda_oe <= 1'b1;
                     end else begin
                        st <= S_IGNORE;
                     end
                  end
               end
               S_AACK, S_CACK: begin
                  if (load_tx) begin
                     shreg <= rd_data;
                     sda_oe <= !rd_data[7];
                     bitcnt <= 4'h1;
                     st <= S_RDATA;
                  end else if (scl_fall) begin
                     sda_oe <= 1'b0;
                     bitcnt <= 4'h0;
                     st <= (st == S_AACK) ? S_CMD : S_WDATA;
                  end
               end
               S_WACK: begin
                  // One data byte per write; more are not acked
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     st <= S_IGNORE;
                  end
               end
               S_RDATA: begin
                  if (scl_fall) begin
                     if (bitcnt == BYTE_BITS) begin
                        sda_oe <= 1'b0;
                        st <= S_RACK;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe <= !shreg[6];
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     master_nack <= sda_s;
                  end else if (load_tx) begin
                     shreg <= rd_data;
                     sda_oe <= !rd_data[7];
                     bitcnt <= 4'h1;
                     st <= S_RDATA;
                  end else if (scl_fall) begin
                     st <= S_IGNORE;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   assign serial_data_line_out = 1'b0;
   assign serial_data_line_oe = sda_oe;

   // ==========================================================
   // Pointer, loaded only by a command byte
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         register_pointer <= PTR_RST;
      end else if (clk_en && cmd_done) begin
         register_pointer <= shreg;
      end
   end

   // Write-only locations feed the read-only mirrors
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         config_value <= CFG_RST;
         local_high_limit <= LIMIT_RST;
         remote_high_limit <= LIMIT_RST;
         critical_limit <= LIMIT_RST;
      end else if (clk_en && wr_strobe) begin
         case (register_pointer)
            LOC_CFG_WR: config_value <= shreg & CFG_USED_MASK;
            LOC_LHL_WR: local_high_limit <= shreg;
            LOC_RHL_WR: remote_high_limit <= shreg;
            LOC_CRIT_WR: critical_limit <= shreg;
            default: ;
         endcase
      end
   end

   // Temperature results
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         local_temp_value <= TEMP_RST;
         remote_temp_value <= TEMP_RST;
      end else if (clk_en && conv_done) begin
         local_temp_value <= local_temp_in;
         remote_temp_value <= remote_temp_in;
      end
   end

   // ==========================================================
   // Sticky flags; a new fault wins over the read clear
   always_comb begin
      next_flags = alarm_flags;
      if (status_rd) begin
         next_flags = alarm_flags & fault_cond;
      end
      if (conv_done) begin
         next_flags = next_flags | fault_cond;
      end
      next_flags = next_flags & FLAG_USED_MASK;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         alarm_flags <= FLAGS_RST;
         high_alarm_out <= 1'b0;
         critical_alarm_out <= 1'b0;
      end else if (clk_en) begin
         alarm_flags <= next_flags;
         high_alarm_out <= next_flags[FLAG_LOCAL_HIGH_FLAG] | next_flags[FLAG_REMOTE_HIGH_FLAG];
         critical_alarm_out <= next_flags[FLAG_LOCAL_CRIT_FLAG] | next_flags[FLAG_REMOTE_CRIT_FLAG];
      end
   end

   // ==========================================================
   // Read data; write-only and reserved give a fixed fill
   always_comb begin
      case (register_pointer)
         LOC_LOCAL_TEMP: rd_data = local_temp_value;
         LOC_REMOTE_TEMP: rd_data = remote_temp_value;
         LOC_FLAGS: rd_data = alarm_flags;
         LOC_CFG_RD: rd_data = config_value;
         LOC_LHL_RD: rd_data = local_high_limit;
         LOC_RHL_RD: rd_data = remote_high_limit;
         LOC_CRIT_RD: rd_data = critical_limit;
         LOC_MAKER: rd_data = MAKER_CODE;
         LOC_REVISION: rd_data = DIE_REVISION;
         default: rd_data = RD_UNDEF;
      endcase
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk iff clk_en);
   endclocking
   default disable iff (!nrst);

   sequence s_byte_sent;
      (st == S_RDATA) && scl_fall && (bitcnt == BYTE_BITS);
   endsequence

   sequence s_master_nack;
      (st == S_RACK) && master_nack && scl_fall && !start_det && !stop_det && !to_expired;
   endsequence

   a_ptr_cmd_load: assert property (cmd_done && !start_det && !stop_det |=>
      register_pointer == $past(shreg))
      else $error("pointer not loaded from command byte");

   a_ptr_holds: assert property (!cmd_done |=> $stable(register_pointer))
      else $error("pointer changed without a command byte");

   a_flag_clear: assert property (status_rd && !conv_done |=>
      alarm_flags == ($past(alarm_flags) & $past(fault_cond)))
      else $error("flag read did not clear released bits");

   a_flag_reserved: assert property ((alarm_flags & ~FLAG_USED_MASK) == 8'h00)
      else $error("reserved flag bit set");

   a_timeout_idle: assert property (to_expired && !start_det |=>
      (st == S_IDLE) && !serial_data_line_oe)
      else $error("timeout did not return bus to idle");

   a_start_restart: assert property (start_det |=> (st == S_ADDR) && (bitcnt == 4'h0))
      else $error("start did not restart address phase");

   a_msb_first: assert property ((st == S_RDATA) |-> sda_oe == !shreg[7])
      else $error("transmitted bit is not the byte msb");

   a_read_release: assert property (s_byte_sent ##1 (st == S_RACK) |-> !sda_oe)
      else $error("data line held during master ack slot");

   a_nack_ends: assert property (s_master_nack |=> (st == S_IGNORE) && !sda_oe)
      else $error("nack did not end the read");

   a_wo_read_fill: assert property (load_tx && (register_pointer == LOC_CFG_WR)
      && !start_det && !stop_det && !to_expired |=> shreg == RD_UNDEF)
      else $error("write-only read gave wrong value");

   a_ro_write_ignored: assert property (wr_strobe && (register_pointer == LOC_CRIT_RD)
      |=> $stable(critical_limit) && $stable(config_value))
      else $error("read-only location was written");

   a_cfg_mirror: assert property (wr_strobe && (register_pointer == LOC_CFG_WR)
      |=> config_value == ($past(shreg) & CFG_USED_MASK))
      else $error("config write not mirrored");

endmodule // ssra_core

// File: include/ssra_pkg.sv
// Shared constants and types for the sensor register access block
package ssra_pkg;

   // ==========================================================
   // Register locations selected by the pointer
   localparam logic [7:0] LOC_LOCAL_TEMP = 8'h00;
   localparam logic [7:0] LOC_REMOTE_TEMP = 8'h01;
   localparam logic [7:0] LOC_FLAGS = 8'h02;
   localparam logic [7:0] LOC_CFG_RD = 8'h03;
   localparam logic [7:0] LOC_LHL_RD = 8'h05;
   localparam logic [7:0] LOC_RHL_RD = 8'h07;
   localparam logic [7:0] LOC_CFG_WR = 8'h09;
   localparam logic [7:0] LOC_LHL_WR = 8'h0B;
   localparam logic [7:0] LOC_RHL_WR = 8'h0D;
   localparam logic [7:0] LOC_CRIT_RD = 8'h42;
   localparam logic [7:0] LOC_CRIT_WR = 8'h5A;
   localparam logic [7:0] LOC_MAKER = 8'hFE;
   localparam logic [7:0] LOC_REVISION = 8'hFF;

   // ==========================================================
   // Reset values and read fill
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] TEMP_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] LIMIT_RST = 8'h7F;
   localparam logic [7:0] RD_UNDEF = 8'hFF;

   // ==========================================================
   // Field layouts
   localparam int FLAG_LOCAL_CRIT_FLAG = 0;
   localparam int FLAG_REMOTE_CRIT_FLAG = 1;
   localparam int FLAG_OPEN = 2;
   localparam int FLAG_REMOTE_HIGH_FLAG = 4;
   localparam int FLAG_LOCAL_HIGH_FLAG = 6;
   localparam logic [7:0] FLAG_USED_MASK = 8'h57;
   localparam logic [7:0] CFG_USED_MASK = 8'hBE;

   // ==========================================================
   // Slave address build: {high part, fixed one, low part}
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_HIGH = 2'h1;
   localparam logic [1:0] PIN_FLOAT = 2'h2;
   localparam logic [2:0] HI_LOW = 3'h1;
   localparam logic [2:0] HI_FLOAT = 3'h2;
   localparam logic [2:0] HI_HIGH = 3'h4;
   localparam logic [2:0] LO_BASE_LOW = 3'h0;
   localparam logic [2:0] LO_BASE_FLOAT = 3'h1;
   localparam logic [2:0] LO_BASE_HIGH = 3'h4;
   localparam logic [2:0] LO_STEP_LOW = 3'h0;
   localparam logic [2:0] LO_STEP_FLOAT = 3'h1;
   localparam logic [2:0] LO_STEP_HIGH = 3'h2;
   localparam logic ADDR_FIXED_ONE = 1'b1;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIMEOUT_MIN_US = 25000;
   localparam int TIMEOUT_MAX_US = 40000;
   localparam int TIMEOUT_US = 32000;
   localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Serial state machine
   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_WDATA, S_WACK,
      S_RDATA, S_RACK, S_IGNORE
   } ssra_state_t;

endpackage

// File: src/ssra_sync.sv
// Two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/10ps
module ssra_sync #(
   parameter int W = 1
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta;

   // ==========================================================
   // First flop is read by the second only
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta <= '1;
         q <= '1;
      end else if (clk_en) begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // ssra_sync

// File: src/ssra_timeout.sv
// Bus line stuck-low watchdog
`timescale 1ns/10ps
module ssra_timeout #(
   parameter int CYC = 320000
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Synchronised bus lines
   input wire logic scl,
   input wire logic sda,
   // One-cycle pulse when a line has been low too long
   output logic expired
);

   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LIMIT = CW'(CYC);

   logic [CW-1:0] cnt;

   // ==========================================================
   // Count while either line is low; saturate so it fires once
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
         expired <= 1'b0;
      end else if (clk_en) begin
         expired <= 1'b0;
         if (scl && sda) begin
            cnt <= '0;
         end else if (cnt != LIMIT) begin
            cnt <= cnt + 1'b1;
            expired <= (cnt == LIMIT - 1'b1);
         end
      end
   end

endmodule // ssra_timeout

// File: tb/ssra_host.sv
// Host master model driving the two-wire bus
`timescale 1ns/10ps
module ssra_host (
   // Clock and resolved data wire
   input wire logic core_clk,
   input wire logic sda,
   // Bus clock and data pull-down
   output logic scl,
   output logic sda_low
);
   // Idle bus: both lines released to their pull-ups
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // ==========================================
   // Start, also a repeated start from clock low
   task automatic start();
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask
   // One bit, sampled late in the high phase so sync delay does not matter
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      sda_low <= !b;
      tick(2);
      scl <= 1'b1;
      tick(3);
      r = sda;
      tick(1);
      scl <= 1'b0;
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // More set means acknowledge and keep reading
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!more, r);
   endtask
endmodule // ssra_host

// File: tb/ssra_core_tb.sv
// Self-checking bench for the sensor register access block
`timescale 1ns/10ps
module ssra_core_tb
   import ssra_pkg::*;
;
   localparam int TO_CYC = 200;
   localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
   localparam logic [7:0] REV = 8'hC3; // arbitrary value
   logic core_clk, nrst, conv_done, scl, host_low, uut_oe, hi_al, cr_al, ack, sdo;
   logic [7:0] lt_in, rt_in, fault, cfg, lhl, rhl, crl, rd;
   int err_total, cmp_count, cyc;
   // Open-drain data wire with pull-up
   wire logic sda = !(host_low | uut_oe);
   logic [7:0] rloc [9] = '{LOC_REMOTE_TEMP, LOC_FLAGS, LOC_CFG_RD, LOC_LHL_RD, LOC_RHL_RD,
      LOC_CRIT_RD, LOC_MAKER, LOC_REVISION, LOC_CFG_WR};
   logic [7:0] rval [9] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'h7F, MAKER, REV, RD_UNDEF};
   logic [7:0] wloc [4] = '{LOC_CFG_WR, LOC_LHL_WR, LOC_RHL_WR, LOC_CRIT_WR};
   logic [7:0] bloc [4] = '{LOC_CFG_RD, LOC_LHL_RD, LOC_RHL_RD, LOC_CRIT_RD};
   logic [7:0] wval [4] = '{8'hFF, 8'h55, 8'hAA, 8'h81};
   logic [7:0] bval [4] = '{8'hBE, 8'h55, 8'hAA, 8'h81};

   ssra_core #(.TIMEOUT_CYCLES(TO_CYC), .MAKER_CODE(MAKER), .DIE_REVISION(REV)) uut (
      .core_clk(core_clk), .nrst(nrst), .clk_en(1'b1),
      .serial_clock_line(scl), .serial_data_line_in(sda),
      .serial_data_line_out(sdo), .serial_data_line_oe(uut_oe),
      .addr_select_0(PIN_LOW), .addr_select_1(PIN_LOW),
      .conv_done(conv_done), .local_temp_in(lt_in), .remote_temp_in(rt_in),
      .fault_cond(fault), .config_value(cfg), .local_high_limit(lhl),
      .remote_high_limit(rhl), .critical_limit(crl),
      .high_alarm_out(hi_al), .critical_alarm_out(cr_al));
   ssra_host host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(host_low));

   // ==========================================
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         summarize();
      end
   end
   // ==========================================
   // Compare and bus tasks
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic send(input logic [7:0] b);
      host.wr_byte(b, ack);
      chk_bit("ack", 1'b1, ack);
   endtask
   task automatic reg_wr(input logic [7:0] p, input logic [7:0] v);
      host.start();
      send(8'h30);
      send(p);
      send(v);
      host.stop();
   endtask
   // Read at the current pointer, address byte only
   task automatic cur_rd(input logic [7:0] exp);
      host.start();
      send(8'h31);
      host.rd_byte(1'b0, rd);
      chk_byte("read", exp, rd);
      host.stop();
   endtask
   task automatic reg_rd(input logic [7:0] p, input logic [7:0] exp);
      host.start();
      send(8'h30);
      send(p);
      cur_rd(exp);
   endtask
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      {nrst, conv_done, lt_in, rt_in, fault, err_total, cmp_count, cyc} = '0;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      host.tick(4);
      cur_rd(TEMP_RST);
      foreach (rloc[i]) reg_rd(rloc[i], rval[i]);
      foreach (wloc[i]) reg_wr(wloc[i], wval[i]);
      foreach (bloc[i]) reg_rd(bloc[i], bval[i]);
      chk_byte("cfg", 8'hBE, cfg);
      chk_byte("crit", 8'h81, crl);
      chk_byte("rhl", 8'hAA, rhl);
      chk_bit("sdo", 1'b0, sdo);
      // Write to a read-only location leaves the pointer there for the next test
      reg_wr(LOC_CRIT_RD, 8'h33);
      reg_rd(LOC_CRIT_RD, 8'h81);
      chk_byte("limit", 8'h55, lhl);
      // Pointer kept; acked read reloads the same register
      host.start();
      send(8'h31);
      host.rd_byte(1'b1, rd);
      chk_byte("first", 8'h81, rd);
      host.rd_byte(1'b0, rd);
      chk_byte("second", 8'h81, rd);
      host.stop();
      // Conversion raising every flag, then only remote high persists
      lt_in <= 8'h19;
      rt_in <= 8'hE7;
      fault <= 8'hFF;
      conv_done <= 1'b1;
      host.tick(1);
      conv_done <= 1'b0;
      fault <= 8'h10;
      host.tick(2);
      chk_bit("crit alarm", 1'b1, cr_al);
      reg_rd(LOC_FLAGS, 8'h57);
      cur_rd(8'h10);
      chk_bit("crit alarm", 1'b0, cr_al);
      chk_bit("high alarm", 1'b1, hi_al);
      reg_rd(LOC_REMOTE_TEMP, 8'hE7);
      reg_rd(LOC_LOCAL_TEMP, 8'h19);
      // Wrong address with the fixed bit cleared is ignored
      host.start();
      host.wr_byte(8'h20, ack);
      chk_bit("nack", 1'b0, ack);
      host.stop();
      // Start in mid-byte restarts the slave
      host.start();
      send(8'h30);
      repeat (3) host.bit_io(1'b0, ack);
      cur_rd(8'h19);
      // Clock held low while the device drives a zero
      host.start();
      send(8'h31);
      host.tick(10);
      chk_bit("drive", 1'b1, uut_oe);
      host.tick(TO_CYC + 100);
      chk_bit("release", 1'b0, uut_oe);
      host.stop();
      cur_rd(8'h19);
      summarize();
   end
endmodule // ssra_core_tb
